// File: switch_link_config_registers.sv
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "link_regs_defines.svh"

module switch_link_config_registers (
  // clock and reset
  input  wire logic                                    clk,
  input  wire logic                                    arst_n,
  // avalon-mm slave, word addressed: address is the register index
  input  wire logic [7:0]                              address,
  input  wire logic                                    read,
  input  wire logic                                    write,
  input  wire logic [31:0]                             writedata,
  input  wire logic [3:0]                              byteenable,
  output logic [31:0]                                  readdata,
  output logic                                         waitrequest,
  // processor link status from the switch
  input  wire logic [`NUM_LINKS-1:0][1:0]              src_target_type,
  input  wire logic [`NUM_LINKS-1:0][7:0]              destination_link_number,
  input  wire logic [`NUM_LINKS-1:0]                   junk_packet,
  input  wire logic [`NUM_LINKS-1:0]                   dest_side_busy,
  input  wire logic [`NUM_LINKS-1:0]                   src_side_busy,
  output logic [`NUM_LINKS-1:0][1:0]                   proc_link_network,
  // external link control and status
  output logic [`NUM_LINKS-1:0]                        link_enable,
  output logic [`NUM_LINKS-1:0]                        link_width_select,
  output logic [`NUM_LINKS-1:0]                        greeting_token_send,
  output logic [`NUM_LINKS-1:0]                        receiver_resync,
  input  wire logic [`NUM_LINKS-1:0]                   rx_overflow,
  input  wire logic [`NUM_LINKS-1:0]                   rx_bad_token,
  input  wire logic [`NUM_LINKS-1:0]                   credit_issued,
  input  wire logic [`NUM_LINKS-1:0]                   credit_received,
  // transmit symbol pacing
  input  wire logic [`NUM_LINKS-1:0]                   sym_req,
  input  wire logic [`NUM_LINKS-1:0]                   sym_last,
  output logic [`NUM_LINKS-1:0]                        sym_ok,
  // static forwarding, indexed by link letter a..h
  output logic [`NUM_LINKS-1:0]                        static_forward_on,
  output logic [`NUM_LINKS-1:0]                        static_dest_processor,
  output logic [`NUM_LINKS-1:0][4:0]                   static_dest_chanend
);
  import link_regs_pkg::*;

  state_t      s;
  state_t      next_s;
  logic [31:0] cur_word;
  logic [31:0] wr_word;
  logic [2:0]  idx;
  logic        hit_pl;
  logic        hit_xl;
  logic        hit_sf;

  function automatic logic in_block(input logic [7:0] a, input logic [7:0] base);
    in_block = (a[7:3] == base[7:3]);
  endfunction : in_block

  function automatic logic [31:0] merge_lanes(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    merge_lanes = (old & ~m) | (wd & m);
  endfunction : merge_lanes

  // register i serves link letter i^2: c,d,a,b,g,h,e,f
  function automatic logic [2:0] static_link(input logic [2:0] i);
    static_link = i ^ `STATIC_SWAP;
  endfunction : static_link

  assign idx    = address[2:0];
  assign hit_pl = in_block(address, `PROC_LINK_BASE);
  assign hit_xl = in_block(address, `EXT_LINK_BASE);
  assign hit_sf = in_block(address, `STATIC_FWD_BASE);

  // one word view of the addressed register; everything unlisted stays zero
  always_comb begin
    cur_word = 32'h0;
    if (hit_pl) begin
      cur_word[`PL_TYPE_MSB:`PL_TYPE_LSB] = src_target_type[idx];
      if (src_side_busy[idx] || dest_side_busy[idx]) begin
        cur_word[`PL_DEST_MSB:`PL_DEST_LSB] = destination_link_number[idx];
      end
      cur_word[`PL_NET_MSB:`PL_NET_LSB] = s.net[idx];
      cur_word[`PL_JUNK_BIT] = junk_packet[idx];
      cur_word[`PL_DST_BIT]  = dest_side_busy[idx];
      cur_word[`PL_SRC_BIT]  = src_side_busy[idx];
    end else if (hit_xl) begin
      cur_word[`XL_EN_BIT]   = s.en[idx];
      cur_word[`XL_WIDE_BIT] = s.wide[idx];
      cur_word[`XL_ERR_BIT]  = s.rx_err[idx];
      cur_word[`XL_RXC_BIT]  = s.rx_cred[idx];
      cur_word[`XL_TXC_BIT]  = s.tx_cred[idx];
      cur_word[`XL_SYM_MSB:`XL_SYM_LSB] = s.sym_gap[idx];
      cur_word[`XL_TOK_MSB:`XL_TOK_LSB] = s.tok_gap[idx];
    end else if (hit_sf) begin
      cur_word[`SF_ON_BIT]   = s.sf_on[idx];
      cur_word[`SF_PROC_BIT] = s.sf_proc[idx];
      cur_word[`SF_CHAN_MSB:`SF_CHAN_LSB] = s.sf_chan[idx];
    end
  end

  // command bits read zero, so an unenabled lane can never fire them
  assign wr_word = merge_lanes(cur_word, writedata, byteenable);

  // pacing: a counter loaded with gap+1 after each symbol, send only at zero
  always_comb begin
    for (int i = 0; i < `NUM_LINKS; i++) begin
      sym_ok[i] = s.en[i] && sym_req[i] && (s.gap_cnt[i] == '0);
    end
  end

  always_comb begin
    next_s        = s;
    next_s.greet  = '0;
    next_s.resync = '0;

    // bus: one wait cycle, write lands and read data stands at the done edge
    case (s.bus)
      BUS_IDLE: begin
        if (read || write) begin
          next_s.bus = BUS_DONE;
          if (read) begin
            next_s.rdata = cur_word;
          end
        end
      end
      BUS_DONE: begin
        next_s.bus = BUS_IDLE;
        if (write && hit_pl) begin
          next_s.net[idx] = wr_word[`PL_NET_MSB:`PL_NET_LSB];
        end
        if (write && hit_xl) begin
          next_s.en[idx]      = wr_word[`XL_EN_BIT];
          next_s.wide[idx]    = wr_word[`XL_WIDE_BIT];
          next_s.greet[idx]   = wr_word[`XL_GREET_BIT];
          next_s.resync[idx]  = wr_word[`XL_RESYNC_BIT];
          next_s.sym_gap[idx] = wr_word[`XL_SYM_MSB:`XL_SYM_LSB];
          next_s.tok_gap[idx] = wr_word[`XL_TOK_MSB:`XL_TOK_LSB];
        end
        if (write && hit_sf) begin
          next_s.sf_on[idx]   = wr_word[`SF_ON_BIT];
          next_s.sf_proc[idx] = wr_word[`SF_PROC_BIT];
          next_s.sf_chan[idx] = wr_word[`SF_CHAN_MSB:`SF_CHAN_LSB];
        end
      end
      default: begin
        next_s.bus = BUS_IDLE;
      end
    endcase

    // link events: clears first, hardware sets last so a same-cycle set wins, except a credit on a disabled link or a credit received while greet is high
    for (int i = 0; i < `NUM_LINKS; i++) begin
      if (s.resync[i]) begin
        next_s.rx_err[i]  = 1'b0;
        next_s.rx_cred[i] = 1'b0;
      end
      if (s.greet[i]) begin
        next_s.tx_cred[i] = 1'b0;
      end
      if (!s.en[i]) begin
        next_s.rx_cred[i] = 1'b0;
        next_s.tx_cred[i] = 1'b0;
      end
      if (rx_overflow[i] || rx_bad_token[i]) begin
        next_s.rx_err[i] = 1'b1;
      end
      if (s.en[i] && credit_issued[i]) begin
        next_s.rx_cred[i] = 1'b1;
      end
      if (s.en[i] && credit_received[i] && !s.greet[i]) begin
        next_s.tx_cred[i] = 1'b1;
      end

      if (!s.en[i]) begin
        next_s.gap_cnt[i] = '0;
      end else if (sym_ok[i]) begin
        next_s.gap_cnt[i] = {1'b0, (sym_last[i] ? s.tok_gap[i] : s.sym_gap[i])}
                            + `GAP_CNT_W'(1);
      end else if (s.gap_cnt[i] != '0) begin
        next_s.gap_cnt[i] = s.gap_cnt[i] - `GAP_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign readdata    = s.rdata;
  assign waitrequest = (read || write) && (s.bus != BUS_DONE);

  // enable also drives pin muxing of overlapping links downstream
  assign link_enable         = s.en;
  assign link_width_select   = s.wide;
  assign greeting_token_send = s.greet;
  assign receiver_resync     = s.resync;
  assign proc_link_network   = s.net;

  always_comb begin
    for (int i = 0; i < `NUM_LINKS; i++) begin
      static_forward_on[static_link(3'(i))]     = s.sf_on[i];
      static_dest_processor[static_link(3'(i))] = s.sf_proc[i];
      static_dest_chanend[static_link(3'(i))]   = s.sf_chan[i];
    end
  end

  // helper for gap checks on link 0: cycles since its last symbol
  logic [`GAP_CNT_W-1:0] since0;
  logic [`GAP_CNT_W-1:0] need0;
  logic                  armed0;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      since0 <= '0;
      need0  <= '0;
      armed0 <= 1'b0;
    end else if (!s.en[0]) begin
      armed0 <= 1'b0;
    end else if (sym_ok[0]) begin
      since0 <= '0;
      armed0 <= 1'b1;
      need0  <= {1'b0, (sym_last[0] ? s.tok_gap[0] : s.sym_gap[0])} + `GAP_CNT_W'(1);
    end else if (since0 != '1) begin
      since0 <= since0 + `GAP_CNT_W'(1);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence req_idle;
    (read || write) && s.bus == BUS_IDLE;
  endsequence

  sequence one_wait_then_done;
    waitrequest ##1 !waitrequest;
  endsequence

  sequence xl_greet_write;
    write && !waitrequest && hit_xl && byteenable[3] && writedata[`XL_GREET_BIT];
  endsequence

  sequence xl_resync_write;
    write && !waitrequest && hit_xl && byteenable[2] && writedata[`XL_RESYNC_BIT];
  endsequence

  // the master holds its request, so the answer always comes after one wait cycle
  a_bus_one_wait: assert property (
    req_idle |-> one_wait_then_done
  ) else $error("bus answer not after exactly one wait cycle");

  a_greet_pulse: assert property (
    xl_greet_write |=> greeting_token_send[$past(idx)] ##1 !greeting_token_send[$past(idx, 2)]
  ) else $error("greeting write did not give a one-cycle pulse");

  a_resync_pulse: assert property (
    xl_resync_write |=> receiver_resync[$past(idx)] ##1 !receiver_resync[$past(idx, 2)]
  ) else $error("resync write did not give a one-cycle pulse");

  a_greet_lane_off: assert property (
    write && !waitrequest && hit_xl && !byteenable[3] |=> greeting_token_send == '0
  ) else $error("greeting fired from a disabled byte lane");

  a_resync_lane_off: assert property (
    write && !waitrequest && hit_xl && !byteenable[2] |=> receiver_resync == '0
  ) else $error("resync fired from a disabled byte lane");

  a_greet_clears: assert property (
    greeting_token_send[0] && !credit_received[0] |=> !s.tx_cred[0]
  ) else $error("greeting did not clear transmit credit");

  a_rx_err_set: assert property (
    (rx_overflow | rx_bad_token) != '0
      |=> (s.rx_err & $past(rx_overflow | rx_bad_token)) == $past(rx_overflow | rx_bad_token)
  ) else $error("receive error not flagged");

  a_rx_err_sticky: assert property (
    ($past(s.rx_err & ~s.resync) & ~s.rx_err) == '0
  ) else $error("receive error dropped without a resync");

  a_resync_clears: assert property (
    ($past(s.resync & ~(rx_overflow | rx_bad_token)) & s.rx_err) == '0
  ) else $error("resync left the receive error set");

  a_rx_cred_set: assert property (
    (credit_issued & s.en) != '0
      |=> (s.rx_cred & $past(credit_issued & s.en)) == $past(credit_issued & s.en)
  ) else $error("issued credit not flagged");

  a_tx_cred_set: assert property (
    (credit_received & s.en & ~s.greet) != '0
      |=> (s.tx_cred & $past(credit_received & s.en & ~s.greet))
          == $past(credit_received & s.en & ~s.greet)
  ) else $error("received credit not flagged");

  a_off_no_credit: assert property (
    ($past(~s.en) & (s.rx_cred | s.tx_cred)) == '0
  ) else $error("credit held by a disabled link");

  a_sym_gap_min: assert property (
    sym_ok[0] && armed0 |-> since0 >= need0
  ) else $error("symbol or token gap shorter than programmed");

  a_sym_spaced: assert property (
    (sym_ok & $past(sym_ok)) == '0
  ) else $error("symbols sent on adjacent cycles");

  a_en_write: assert property (
    write && !waitrequest && hit_xl && byteenable[3]
      |=> link_enable[$past(idx)] == $past(writedata[`XL_EN_BIT])
          && link_width_select[$past(idx)] == $past(writedata[`XL_WIDE_BIT])
  ) else $error("enable or width write not applied");

  a_gap_write: assert property (
    write && !waitrequest && hit_xl && byteenable == 4'hf
      |=> s.sym_gap[$past(idx)] == $past(writedata[`XL_SYM_MSB:`XL_SYM_LSB])
          && s.tok_gap[$past(idx)] == $past(writedata[`XL_TOK_MSB:`XL_TOK_LSB])
  ) else $error("gap write not applied");

  a_sf_write: assert property (
    write && !waitrequest && hit_sf && byteenable == 4'hf
      |=> s.sf_on[$past(idx)] == $past(writedata[`SF_ON_BIT])
          && s.sf_proc[$past(idx)] == $past(writedata[`SF_PROC_BIT])
          && s.sf_chan[$past(idx)] == $past(writedata[`SF_CHAN_MSB:`SF_CHAN_LSB])
  ) else $error("static forwarding write not applied");

  a_pl_read: assert property (
    read && !waitrequest && hit_pl
      |-> readdata[`PL_NET_MSB:`PL_NET_LSB] == proc_link_network[idx]
          && readdata[`PL_TYPE_MSB:`PL_TYPE_LSB] == $past(src_target_type[idx])
          && readdata[`PL_JUNK_BIT] == $past(junk_packet[idx])
          && readdata[`PL_DST_BIT] == $past(dest_side_busy[idx])
          && readdata[`PL_SRC_BIT] == $past(src_side_busy[idx])
  ) else $error("processor link status read wrong");

  a_pl_reserved: assert property (
    read && !waitrequest && hit_pl |-> (readdata & ~`PL_USED_MASK) == 32'h0
  ) else $error("reserved processor link bits not zero");

  a_xl_reserved: assert property (
    read && !waitrequest && hit_xl |-> (readdata & ~`XL_USED_MASK) == 32'h0
  ) else $error("reserved external link bits not zero");

  a_sf_reserved: assert property (
    read && !waitrequest && hit_sf |-> (readdata & ~`SF_USED_MASK) == 32'h0
  ) else $error("reserved static forwarding bits not zero");

  a_xl_read: assert property (
    read && !waitrequest && hit_xl
      |-> readdata[`XL_EN_BIT] == link_enable[idx] && readdata[`XL_WIDE_BIT] == link_width_select[idx]
  ) else $error("enable or width read wrong");

  a_cmd_read_zero: assert property (
    read && !waitrequest && hit_xl |-> readdata[`XL_GREET_BIT:`XL_RESYNC_BIT] == 2'h0
  ) else $error("command bits did not read zero");

  a_unmapped_zero: assert property (
    read && !waitrequest && !hit_pl && !hit_xl && !hit_sf |-> readdata == 32'h0
  ) else $error("unmapped read not zero");

  a_static_map: assert property (
    static_forward_on[2] == s.sf_on[0] && static_dest_chanend[0] == s.sf_chan[2]
  ) else $error("static register to link letter map broken");

  a_net_write: assert property (
    write && !waitrequest && hit_pl && byteenable[0] |=>
      proc_link_network[$past(idx)] == $past(writedata[`PL_NET_MSB:`PL_NET_LSB])
  ) else $error("network number write not applied");

  a_dest_gated: assert property (
    read && !waitrequest && hit_pl && !src_side_busy[idx] && !dest_side_busy[idx]
      |-> readdata[`PL_DEST_MSB:`PL_DEST_LSB] == 8'h0
  ) else $error("destination link shown while idle");

endmodule : switch_link_config_registers

// File: link_regs_defines.svh
`ifndef LINK_REGS_DEFINES_SVH
`define LINK_REGS_DEFINES_SVH

`define NUM_LINKS        8
`define PROC_LINK_BASE   8'h40
`define EXT_LINK_BASE    8'h80
`define STATIC_FWD_BASE  8'ha0

`define PL_TYPE_MSB      25
`define PL_TYPE_LSB      24
`define PL_DEST_MSB      23
`define PL_DEST_LSB      16
`define PL_NET_MSB       5
`define PL_NET_LSB       4
`define PL_JUNK_BIT      2
`define PL_DST_BIT       1
`define PL_SRC_BIT       0

`define XL_EN_BIT        31
`define XL_WIDE_BIT      30
`define XL_ERR_BIT       27
`define XL_RXC_BIT       26
`define XL_TXC_BIT       25
`define XL_GREET_BIT     24
`define XL_RESYNC_BIT    23
`define XL_SYM_MSB       21
`define XL_SYM_LSB       11
`define XL_TOK_MSB       10
`define XL_TOK_LSB       0

`define SF_ON_BIT        31
`define SF_PROC_BIT      8
`define SF_CHAN_MSB      4
`define SF_CHAN_LSB      0

`define PL_USED_MASK     32'h03ff0037
`define XL_USED_MASK     32'hce3fffff
`define SF_USED_MASK     32'h8000011f

`define GAP_W            11
`define GAP_CNT_W        12
`define STATIC_SWAP      3'h2

`endif

// File: link_regs_pkg.sv
`include "link_regs_defines.svh"

package link_regs_pkg;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0,
    BUS_DONE = 2'h1
  } bus_state_t;

  typedef struct packed {
    bus_state_t                                bus;
    logic [31:0]                               rdata;
    logic [`NUM_LINKS-1:0][1:0]                net;
    logic [`NUM_LINKS-1:0]                     en;
    logic [`NUM_LINKS-1:0]                     wide;
    logic [`NUM_LINKS-1:0]                     rx_err;
    logic [`NUM_LINKS-1:0]                     rx_cred;
    logic [`NUM_LINKS-1:0]                     tx_cred;
    logic [`NUM_LINKS-1:0]                     greet;
    logic [`NUM_LINKS-1:0]                     resync;
    logic [`NUM_LINKS-1:0][`GAP_W-1:0]         sym_gap;
    logic [`NUM_LINKS-1:0][`GAP_W-1:0]         tok_gap;
    logic [`NUM_LINKS-1:0][`GAP_CNT_W-1:0]     gap_cnt;
    logic [`NUM_LINKS-1:0]                     sf_on;
    logic [`NUM_LINKS-1:0]                     sf_proc;
    logic [`NUM_LINKS-1:0][4:0]                sf_chan;
  } state_t;

endpackage : link_regs_pkg

// File: link_far_end.sv
`timescale 1ns/100ps
`include "link_regs_defines.svh"

module link_far_end (
  // bench control
  input  wire logic                         clk,
  input  wire logic                         arst_n,
  input  wire logic                         step,
  input  wire logic                         fire,
  input  wire logic                         last_mode,
  input  wire logic [1:0]                   fire_kind,
  input  wire logic [2:0]                   fire_link,
  input  wire logic [31:0]                  pat,
  // switch status and link events
  output logic [`NUM_LINKS-1:0][1:0]        src_target_type,
  output logic [`NUM_LINKS-1:0][7:0]        destination_link_number,
  output logic [`NUM_LINKS-1:0]             junk_packet,
  output logic [`NUM_LINKS-1:0]             dest_side_busy,
  output logic [`NUM_LINKS-1:0]             src_side_busy,
  output logic [`NUM_LINKS-1:0]             rx_overflow,
  output logic [`NUM_LINKS-1:0]             rx_bad_token,
  output logic [`NUM_LINKS-1:0]             credit_issued,
  output logic [`NUM_LINKS-1:0]             credit_received,
  output logic [`NUM_LINKS-1:0]             sym_req,
  output logic [`NUM_LINKS-1:0]             sym_last
);
  logic [31:0]      held;
  logic [3:0][7:0]  ev;
  // status only moves on step, so a read never straddles a change
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      held <= '0;
      ev   <= '0;
    end else begin
      ev <= '0;
      if (step) held <= pat;
      if (fire) ev[fire_kind] <= 8'h1 << fire_link;
    end
  end
  always_comb begin
    for (int i = 0; i < `NUM_LINKS; i++) begin
      src_target_type[i]         = held[2*i+:2];
      destination_link_number[i] = held[31:24] + 8'(i);
    end
  end
  assign junk_packet     = held[23:16];
  assign dest_side_busy  = held[15:8];
  assign src_side_busy   = held[7:0];
  assign rx_overflow     = ev[0];
  assign rx_bad_token    = ev[1];
  assign credit_issued   = ev[2];
  assign credit_received = ev[3];
  // transmitter always has a symbol waiting, so sym_ok spacing is pure pacing
  assign sym_req         = '1;
  assign sym_last        = {`NUM_LINKS{last_mode}};
endmodule : link_far_end

// File: tb_switch_link_config_registers.sv
`timescale 1ns/100ps
`include "link_regs_defines.svh"

module tb_switch_link_config_registers;
  import link_regs_pkg::*;
  logic                     clk, arst_n, read, write, step, fire, last_mode, waitrequest;
  logic [7:0]               address;
  logic [31:0]              writedata, readdata, pat, q, wd;
  logic [1:0]               fire_kind;
  logic [3:0]               be;
  logic [2:0]               fire_link;
  logic [`NUM_LINKS-1:0][1:0] stt, net;
  logic [`NUM_LINKS-1:0][7:0] dln;
  logic [`NUM_LINKS-1:0][4:0] sdc;
  logic [`NUM_LINKS-1:0]    junk, dsb, ssb, len, lws, gts, rrs, rxo, rxb, cri, crr;
  logic [`NUM_LINKS-1:0]    sreq, slast, sok, sfo, sdp;
  int                       n_errors = 0, check_count = 0, cyc = 0, i, k, n, m;
  int                       t[3];
  localparam logic [2:0]    letter [8] = '{3'h2, 3'h3, 3'h0, 3'h1, 3'h6, 3'h7, 3'h4, 3'h5};

  switch_link_config_registers uut (.clk(clk), .arst_n(arst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(be), .readdata(readdata),
    .waitrequest(waitrequest), .src_target_type(stt), .destination_link_number(dln),
    .junk_packet(junk), .dest_side_busy(dsb), .src_side_busy(ssb), .proc_link_network(net),
    .link_enable(len), .link_width_select(lws), .greeting_token_send(gts),
    .receiver_resync(rrs), .rx_overflow(rxo), .rx_bad_token(rxb), .credit_issued(cri),
    .credit_received(crr), .sym_req(sreq), .sym_last(slast), .sym_ok(sok),
    .static_forward_on(sfo), .static_dest_processor(sdp), .static_dest_chanend(sdc));
  link_far_end far (.clk(clk), .arst_n(arst_n), .step(step), .fire(fire), .last_mode(last_mode),
    .fire_kind(fire_kind), .fire_link(fire_link), .pat(pat), .src_target_type(stt),
    .destination_link_number(dln), .junk_packet(junk), .dest_side_busy(dsb),
    .src_side_busy(ssb), .rx_overflow(rxo), .rx_bad_token(rxb), .credit_issued(cri),
    .credit_received(crr), .sym_req(sreq), .sym_last(slast));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  task end_of_test;
    if (n_errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  task chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word
  task chk_bits(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bits
  // request held until the rising edge that samples waitrequest low; data taken there
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int w;
    @(posedge clk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    w = 0;
    do begin
      @(posedge clk);
      w++;
    end while (waitrequest !== 1'b0 && w < 40);
    if (w >= 40) begin
      n_errors++;
      end_of_test();
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task fire_ev(input logic [1:0] kd, input logic [2:0] l);
    @(posedge clk);
    fire <= 1'b1;
    fire_kind <= kd;
    fire_link <= l;
    @(posedge clk);
    fire <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : fire_ev
  task pulse_chk(input logic [7:0] eg, input logic [7:0] er);
    logic [7:0] ag, ar;
    int c;
    ag = '0;
    ar = '0;
    c = 0;
    repeat (4) begin
      @(negedge clk);
      ag |= gts;
      ar |= rrs;
      c += int'(gts != 0) + int'(rrs != 0);
    end
    chk_bits("greet", eg, ag);
    chk_bits("resync", er, ar);
    chk_word("pulse cycles", 32'(int'(eg != 0) + int'(er != 0)), 32'(c));
  endtask : pulse_chk
  function automatic logic [31:0] pl_exp(input int l, input logic [1:0] nt);
    logic [7:0] d;
    d = pat[31:24] + 8'(l);
    if (!(pat[8+l] | pat[l])) d = 8'h00;
    return {6'h00, pat[2*l+:2], d, 10'h000, nt, 1'b0, pat[16+l], pat[8+l], pat[l]};
  endfunction : pl_exp

  initial begin
    arst_n = 1'b0; read = 1'b0; write = 1'b0; address = 8'h00; writedata = 32'h0;
    step = 1'b0; fire = 1'b0; fire_kind = 2'h0; fire_link = 3'h0; last_mode = 1'b0; pat = 32'h0;
    be = 4'hf;
    q = $urandom(66);
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    chk_word("net reset", 32'h0, 32'(net));
    for (i = 0; i < 8; i++) begin
      bus(0, 8'h80 + 8'(i), 32'h0);
      chk_word("ext reset", 32'h0, q);
      bus(0, 8'ha0 + 8'(i), 32'h0);
      chk_word("static reset", 32'h0, q);
    end
    for (k = 0; k < 4; k++) begin
      pat <= (k == 0) ? 32'hffffffff : (k == 1) ? 32'h00ff0000 : $urandom();
      step <= 1'b1;
      @(posedge clk);
      step <= 1'b0;
      for (i = 0; i < 8; i++) begin
        wd = $urandom();
        bus(1, 8'h40 + 8'(i), wd);
        bus(0, 8'h40 + 8'(i), 32'h0);
        chk_word("proc status", pl_exp(i, wd[5:4]), q);
        chk_word("net out", 32'(wd[5:4]), 32'(net[i]));
      end
    end
    for (i = 0; i < 8; i++) begin
      wd = (i == 0) ? 32'hffffffff : $urandom();
      bus(1, 8'h80 + 8'(i), wd);
      pulse_chk(8'(wd[24]) << i, 8'(wd[23]) << i);
      bus(0, 8'h80 + 8'(i), 32'h0);
      chk_word("ext rw", wd & 32'hc03fffff, q);
      chk_word("en width", 32'({wd[31], wd[30]}), 32'({len[i], lws[i]}));
    end
    bus(1, 8'h88, 32'hffffffff);
    bus(0, 8'h88, 32'h0);
    chk_word("unmapped", 32'h0, q);
    bus(1, 8'h83, 32'h80000000);
    fire_ev(2'h3, 3'h3);
    fire_ev(2'h2, 3'h3);
    fire_ev(2'h0, 3'h3);
    bus(0, 8'h83, 32'h0);
    chk_word("flags set", 32'h8e000000, q);
    bus(1, 8'h83, 32'h81000000);
    pulse_chk(8'h08, 8'h00);
    bus(0, 8'h83, 32'h0);
    chk_word("after greet", 32'h8c000000, q);
    bus(1, 8'h83, 32'h80800000);
    pulse_chk(8'h00, 8'h08);
    bus(0, 8'h83, 32'h0);
    chk_word("after resync", 32'h80000000, q);
    fire_ev(2'h1, 3'h3);
    bus(0, 8'h83, 32'h0);
    chk_word("bad token", 32'h88000000, q);
    be <= 4'h3;
    bus(1, 8'h83, 32'hff800000);
    be <= 4'hf;
    pulse_chk(8'h00, 8'h00);
    bus(0, 8'h83, 32'h0);
    chk_word("lane merge", 32'h88000000, q);
    bus(1, 8'h84, 32'h0);
    fire_ev(2'h3, 3'h4);
    bus(0, 8'h84, 32'h0);
    chk_word("disabled credit", 32'h0, q);
    for (k = 0; k < 2; k++) begin
      last_mode <= k[0];
      n = $urandom_range(6, 0);
      m = $urandom_range(6, 0);
      // disabling first clears any long gap still counting from earlier writes
      bus(1, 8'h80, 32'h0);
      bus(1, 8'h80, 32'h80000000 | 32'(n << 11) | 32'(m));
      for (i = 0; i < 3; i++) begin
        t[i] = -1;
        repeat (40) if (t[i] < 0) begin
          @(negedge clk);
          if (sok[0] === 1'b1) t[i] = cyc;
        end
      end
      chk_word("sym gap", 32'((k == 1) ? m + 2 : n + 2), 32'(t[2] - t[1]));
    end
    for (i = 0; i < 8; i++) begin
      wd = (i == 0) ? 32'hffffffff : $urandom();
      bus(1, 8'ha0 + 8'(i), wd);
      bus(0, 8'ha0 + 8'(i), 32'h0);
      chk_word("static rw", wd & 32'h8000011f, q);
      chk_word("static out", 32'({wd[31], wd[8], wd[4:0]}),
               32'({sfo[letter[i]], sdp[letter[i]], sdc[letter[i]]}));
    end
    end_of_test();
  end

  initial begin
    #300000;
    n_errors++;
    end_of_test();
  end
endmodule : tb_switch_link_config_registers
